// ---- core/ahbip_pkg.sv ----
// Shared constants for the host bus and interrupt acknowledge port
package ahbip_pkg;
   localparam int          DATA_W          = 8;
   localparam int          CLK_PERIOD_NS   = 40;
   localparam int          RECOVERY_PCLKS  = 4;
   localparam int          SYNC_STAGES     = 2;
   localparam int          ACK_SETTLE_NS   = 160;
   localparam int          ACK_SETTLE_CYC  =
      (ACK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          STROBE_LOW_CYC  = 4;
   localparam int          DATA_DELAY_CYC  = 1;
   localparam logic [7:0]  VECTOR_RST      = 8'h00;
   localparam logic [7:0]  DATA_RST        = 8'h00;
   localparam logic [1:0]  ADDR_RST        = 2'h0;
endpackage

// ---- core/ahbip_if.sv ----
// Parallel host bus with strobes, select lines and priority chain
`timescale 1ns/10ps
interface ahbip_if;
   logic       ce_n;
   logic       rd_n;
   logic       wr_n;
   logic       chan_sel;
   logic       dc_sel;
   logic       interrupt_ack_n;
   logic [7:0] host_data;
   logic       host_data_oe;
   logic [7:0] dev_data;
   logic       dev_data_oe;
   logic       priority_chain_in;
   logic       priority_chain_out;
   logic       int_n;
   wire  [7:0] data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);

   modport dev (
      input  ce_n, rd_n, wr_n, chan_sel, dc_sel, interrupt_ack_n, data_bus,
      input  priority_chain_in,
      output dev_data, dev_data_oe, priority_chain_out, int_n
   );
   modport host (
      output ce_n, rd_n, wr_n, chan_sel, dc_sel, interrupt_ack_n, host_data, host_data_oe,
      input  data_bus, int_n
   );
endinterface

// ---- core/ahbip_host.sv ----
// Host end: issues reads, writes and acknowledge cycles with spacing
`timescale 1ns/10ps
module ahbip_host #(
   parameter int RECOVERY = ahbip_pkg::RECOVERY_PCLKS,
   parameter int SETTLE   = ahbip_pkg::ACK_SETTLE_CYC
) (
   input  wire logic       mclk_i,
   input  wire logic       reset_n_i,
   ahbip_if.host           bus,
   input  wire logic       req_i,
   input  wire logic       req_write_i,
   input  wire logic       req_ack_i,
   input  wire logic       req_chan_i,
   input  wire logic       req_dc_i,
   input  wire logic [7:0] req_data_i,
   output logic            busy_o,
   output logic            done_o,
   output logic [7:0]      rdata_o
);
   typedef enum logic [2:0] {
      AHBIP_IDLE   = 3'b000,
      AHBIP_SETTLE = 3'b001,
      AHBIP_LOW    = 3'b010,
      AHBIP_REC    = 3'b011
   } ahbip_hst_t;

   ahbip_hst_t  st_reg, st_next;
   logic [3:0]  cnt_reg;
   logic [3:0]  since_reg;
   logic        wr_reg, ack_reg, ce_reg, rd_reg, wrs_reg, ia_reg, oe_reg;
   logic        ch_reg, dc_reg;
   logic [7:0]  d_reg;

   // Spacing from the previous strobe fall to this device
   wire spaced = since_reg >= 4'(RECOVERY);
   wire cnt_done = cnt_reg == 4'h0;

   always_comb begin
      st_next = st_reg;
      case (st_reg)
         AHBIP_IDLE:   if (req_i && spaced) st_next = req_ack_i ? AHBIP_SETTLE : AHBIP_LOW;
         AHBIP_SETTLE: if (cnt_done) st_next = AHBIP_LOW;
         AHBIP_LOW:    if (cnt_done) st_next = AHBIP_REC;
         AHBIP_REC:    st_next = AHBIP_IDLE;
         default:      st_next = AHBIP_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         st_reg <= AHBIP_IDLE;
         cnt_reg <= 4'h0;
         since_reg <= 4'hf;
         {wr_reg, ack_reg, ch_reg, dc_reg, oe_reg} <= 5'h00;
         {ce_reg, rd_reg, wrs_reg, ia_reg} <= 4'hf;
         d_reg <= ahbip_pkg::DATA_RST;
         done_o <= 1'b0;
         rdata_o <= ahbip_pkg::DATA_RST;
      end else begin
         st_reg <= st_next;
         done_o <= 1'b0;
         if (since_reg != 4'hf) since_reg <= since_reg + 4'h1;
         if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
         case (st_reg)
            AHBIP_IDLE: if (req_i && spaced) begin
               // Selects stay fixed for the whole cycle
               {wr_reg, ack_reg, ch_reg, dc_reg} <= {req_write_i, req_ack_i, req_chan_i, req_dc_i};
               d_reg <= req_data_i;
               ce_reg <= req_ack_i;
               ia_reg <= ~req_ack_i;
               cnt_reg <= req_ack_i ? 4'(SETTLE - 1) : 4'(ahbip_pkg::STROBE_LOW_CYC - 1);
               if (!req_ack_i) begin
                  rd_reg <= req_write_i;
                  wrs_reg <= ~req_write_i;
                  oe_reg <= req_write_i;
                  since_reg <= 4'h0;
               end
            end
            AHBIP_SETTLE: if (cnt_done) begin
               rd_reg <= 1'b0;
               since_reg <= 4'h0;
               cnt_reg <= 4'(ahbip_pkg::STROBE_LOW_CYC - 1);
            end
            AHBIP_LOW: if (cnt_done) begin
               if (!wr_reg) rdata_o <= bus.data_bus;
               {ce_reg, rd_reg, wrs_reg, ia_reg} <= 4'hf;
            end
            AHBIP_REC: begin
               oe_reg <= 1'b0;
               done_o <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   assign bus.ce_n            = ce_reg;
   assign bus.rd_n            = rd_reg;
   assign bus.wr_n            = wrs_reg;
   assign bus.chan_sel        = ch_reg;
   assign bus.dc_sel          = dc_reg;
   assign bus.interrupt_ack_n = ia_reg;
   assign bus.host_data       = d_reg;
   assign bus.host_data_oe    = oe_reg;
   assign busy_o              = st_reg != AHBIP_IDLE;
endmodule

// ---- core/ahbip_dev.sv ----
// Device end: strobe synchroniser, register access and acknowledge cycle
`timescale 1ns/10ps
module ahbip_dev #(
   parameter int SYNC = ahbip_pkg::SYNC_STAGES
) (
   input  wire logic       mclk_i,
   input  wire logic       reset_n_i,
   ahbip_if.dev            bus,
   input  wire logic       int_pending_i,
   input  wire logic       vector_enable_i,
   input  wire logic [7:0] vector_i,
   input  wire logic       ius_clear_i,
   input  wire logic [7:0] rd_data_i,
   output logic            wr_stb_o,
   output logic            rd_stb_o,
   output logic [7:0]      wr_data_o,
   output logic            wr_chan_o,
   output logic            wr_dc_o,
   output logic            rd_chan_o,
   output logic            rd_dc_o,
   output logic            ius_o,
   output logic            ack_claim_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Strobe synchronisers
   logic [SYNC-1:0] rd_sync_reg;
   logic [SYNC-1:0] wr_sync_reg;
   logic            rd_act_reg;
   logic            wr_act_reg;

   // Effective read and write strobes need enable too; the acknowledge strobe needs interrupt_ack_n instead
   wire rd_raw  = ~bus.ce_n & ~bus.rd_n;
   wire wr_raw  = ~bus.ce_n & ~bus.wr_n;
   wire ack_raw = ~bus.interrupt_ack_n & ~bus.rd_n;
   wire rd_s    = rd_sync_reg[SYNC-1];
   wire wr_s    = wr_sync_reg[SYNC-1];

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         rd_sync_reg <= '0;
      end else begin
         rd_sync_reg <= {rd_sync_reg[SYNC-2:0], rd_raw | ack_raw};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wr_sync_reg <= '0;
      end else begin
         wr_sync_reg <= {wr_sync_reg[SYNC-2:0], wr_raw};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         rd_act_reg <= 1'b0;
      end else begin
         rd_act_reg <= rd_s;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wr_act_reg <= 1'b0;
      end else begin
         wr_act_reg <= wr_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoding
   logic [7:0] dout_reg;
   logic       doe_reg;
   logic       ius_reg;
   logic       chain_out_reg;
   logic       int_n_reg;
   logic [7:0] wr_hold_reg;
   logic [1:0] wr_sel_hold_reg;

   wire rd_rise     = rd_s & ~rd_act_reg;
   wire wr_fall_end = ~wr_s & wr_act_reg;
   wire ack_cycle   = ~bus.interrupt_ack_n;
   wire reg_read    = rd_rise & ~ack_cycle;
   wire claim       = rd_rise & ack_cycle & int_pending_i & bus.priority_chain_in;
   wire vec_drive   = claim & vector_enable_i;
   wire ius_active  = int_pending_i & ~ius_reg;
   wire chain_next  = bus.priority_chain_in & ~int_pending_i & ~ius_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Write path
   // Data sampled while the effective write is low, so it may come late
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wr_hold_reg <= ahbip_pkg::DATA_RST;
      end else if (wr_raw) begin
         wr_hold_reg <= bus.data_bus;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wr_sel_hold_reg <= 2'h0;
      end else if (wr_raw) begin
         wr_sel_hold_reg <= {bus.chan_sel, bus.dc_sel};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wr_stb_o <= 1'b0;
      end else begin
         wr_stb_o <= wr_fall_end & bus.interrupt_ack_n;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wr_data_o <= ahbip_pkg::DATA_RST;
      end else if (wr_fall_end) begin
         wr_data_o <= wr_hold_reg;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wr_chan_o <= 1'b0;
      end else if (wr_fall_end) begin
         wr_chan_o <= wr_sel_hold_reg[1];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wr_dc_o <= 1'b0;
      end else if (wr_fall_end) begin
         wr_dc_o <= wr_sel_hold_reg[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         rd_stb_o <= 1'b0;
      end else begin
         rd_stb_o <= reg_read;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         rd_chan_o <= 1'b0;
      end else begin
         rd_chan_o <= bus.chan_sel;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         rd_dc_o <= 1'b0;
      end else begin
         rd_dc_o <= bus.dc_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Acknowledge and priority chain
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         ack_claim_o <= 1'b0;
      end else begin
         ack_claim_o <= claim;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         ius_reg <= 1'b0;
      end else if (claim) begin
         ius_reg <= 1'b1;
      end else if (ius_clear_i) begin
         ius_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         chain_out_reg <= 1'b0;
      end else begin
         chain_out_reg <= chain_next;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         int_n_reg <= 1'b1;
      end else begin
         int_n_reg <= ~ius_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data drive
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         dout_reg <= ahbip_pkg::DATA_RST;
      end else if (reg_read) begin
         dout_reg <= rd_data_i;
      end else if (vec_drive) begin
         dout_reg <= vector_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         doe_reg <= 1'b0;
      end else if (reg_read || vec_drive) begin
         doe_reg <= 1'b1;
      end else if (!rd_s) begin
         doe_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus connections
   assign bus.dev_data           = dout_reg;
   assign bus.dev_data_oe        = doe_reg;
   assign bus.priority_chain_out = chain_out_reg;
   assign bus.int_n              = int_n_reg;
   assign ius_o                  = ius_reg;
endmodule

// ---- testbench/ahbip_checker.sv ----
// Assertions on the bus between the host end and the device end
`timescale 1ns/10ps
module ahbip_checker (
   input wire logic       mclk_i,
   input wire logic       reset_n_i,
   input wire logic       ce_n,
   input wire logic       rd_n,
   input wire logic       wr_n,
   input wire logic       chan_sel,
   input wire logic       dc_sel,
   input wire logic       interrupt_ack_n,
   input wire logic       priority_chain_in,
   input wire logic       dev_data_oe,
   input wire logic [7:0] data_bus
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////////////////////////////////////////////
   sequence sync_wait_s;
      !dev_data_oe [*2];
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   chk_strobe_gap: assert property (
      $fell(rd_n & wr_n) |=> !$fell(rd_n & wr_n) [*3]) else $error("Strobes too close");
   chk_read_synced: assert property (
      $fell(rd_n) && !ce_n && interrupt_ack_n && !dev_data_oe |-> sync_wait_s ##[1:2] dev_data_oe)
      else $error("Read drive timing wrong");
   chk_read_sel_hold: assert property (
      !rd_n && !$past(rd_n) |-> $stable(chan_sel) && $stable(dc_sel) && $stable(interrupt_ack_n))
      else $error("Selects moved in read");
   chk_read_gated: assert property (
      $rose(dev_data_oe) && interrupt_ack_n |-> $past(ce_n, 2) == 1'b0 && $past(rd_n, 2) == 1'b0)
      else $error("Drive without enabled read");
   chk_write_sel_hold: assert property (
      !wr_n && !$past(wr_n) |-> $stable(chan_sel) && $stable(dc_sel) && $stable(interrupt_ack_n))
      else $error("Selects moved in write");
   chk_write_quiet: assert property (
      !wr_n && !ce_n |-> !$rose(dev_data_oe)) else $error("Drive started in write");
   chk_ack_settle: assert property (
      $fell(interrupt_ack_n) |-> rd_n [*4]) else $error("Acknowledge settle too short");
   chk_vector_hold: assert property (
      $rose(dev_data_oe) && !interrupt_ack_n |-> !rd_n ##1 $stable(data_bus))
      else $error("Vector not held");
   chk_unclaimed_idle: assert property (
      $fell(rd_n) && !interrupt_ack_n && !priority_chain_in |-> !dev_data_oe [*6])
      else $error("Unclaimed cycle drove bus");
endmodule

// ---- testbench/async_host_bus_interrupt_ack_n_port_tb_top.sv ----
// Testbench joining the host end and the device end over the bus
`timescale 1ns/10ps
module async_host_bus_interrupt_ack_n_port_tb_top;
   logic       mclk_i = 1'b0;
   logic       reset_n_i = 1'b0;
   logic       req_i = 1'b0, req_write_i = 1'b0, req_ack_i = 1'b0, req_chan_i = 1'b0;
   logic       req_dc_i = 1'b0, int_pending_i = 1'b0, vector_enable_i = 1'b0, ius_clear_i = 1'b0;
   logic [7:0] req_data_i = 8'h00, vector_i = 8'h00, rd_data_i = 8'h00;
   logic       busy_o, done_o, wr_stb_o, wr_chan_o, wr_dc_o, rd_chan_o, rd_dc_o, ius_o, k;
   logic       ack_claim_o;
   logic [7:0] rdata_o, wr_data_o;
   logic [9:0] wcap = 10'h000;
   int         errors = 0, total_checks = 0, ccnt = 0, rcnt = 0, c, r, i;
   logic       rd_stb_o;
   ahbip_if    bus ();
   always #20 mclk_i = ~mclk_i;
   ////////////////////////////////////////////////////////////////////////////////
   ahbip_host u_ahbip_host (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus(bus), .req_i(req_i),
      .req_write_i(req_write_i), .req_ack_i(req_ack_i), .req_chan_i(req_chan_i),
      .req_dc_i(req_dc_i), .req_data_i(req_data_i), .busy_o(busy_o), .done_o(done_o),
      .rdata_o(rdata_o));
   ahbip_dev u_ahbip_dev (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus(bus),
      .int_pending_i(int_pending_i), .vector_enable_i(vector_enable_i), .vector_i(vector_i),
      .ius_clear_i(ius_clear_i), .rd_data_i(rd_data_i), .wr_stb_o(wr_stb_o), .rd_stb_o(rd_stb_o),
      .wr_data_o(wr_data_o), .wr_chan_o(wr_chan_o), .wr_dc_o(wr_dc_o), .rd_chan_o(rd_chan_o),
      .rd_dc_o(rd_dc_o), .ius_o(ius_o), .ack_claim_o(ack_claim_o));
   ahbip_checker u_ahbip_checker (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_n(bus.ce_n),
      .rd_n(bus.rd_n), .wr_n(bus.wr_n), .chan_sel(bus.chan_sel), .dc_sel(bus.dc_sel),
      .interrupt_ack_n(bus.interrupt_ack_n), .priority_chain_in(bus.priority_chain_in),
      .dev_data_oe(bus.dev_data_oe), .data_bus(bus.data_bus));
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk_i) begin
      if (wr_stb_o === 1'b1) wcap = {wr_chan_o, wr_dc_o, wr_data_o};
      if (ack_claim_o === 1'b1) ccnt++;
      if (rd_stb_o === 1'b1) rcnt++;
   end
   task automatic compare(input logic [9:0] got, input logic [9:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic access(input logic w, a, ch, d, input logic [7:0] v);
      int n;
      @(posedge mclk_i);
      {req_i, req_write_i, req_ack_i, req_chan_i, req_dc_i, req_data_i} <= {1'b1, w, a, ch, d, v};
      for (n = 0; n < 40 && done_o !== 1'b1; n++) begin
         @(posedge mclk_i);
         if (busy_o === 1'b1) req_i <= 1'b0;
      end
      if (n == 40) begin
         errors++;
         $display("[FAIL] %0t no completion", $time);
         tally_and_finish();
      end
      repeat (4) @(posedge mclk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      bus.priority_chain_in = 1'b1;
      repeat (3) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      for (i = 0; i < 4; i++) begin
         access(1'b1, 1'b0, i[1], i[0], 8'h5a + 8'(i));
         compare(wcap, {i[1], i[0], 8'h5a + 8'(i)});
         rd_data_i <= 8'hc0 + 8'(i);
         r = rcnt;
         access(1'b0, 1'b0, i[1], i[0], 8'h00);
         compare(10'(rcnt - r), 10'h001);
         compare({rd_chan_o, rd_dc_o, rdata_o}, {i[1], i[0], 8'hc0 + 8'(i)});
      end
      for (i = 0; i < 4; i++) begin
         {int_pending_i, vector_enable_i, bus.priority_chain_in} <= 3'h7 ^ (3'h1 << i);
         vector_i <= 8'h96 ^ 8'(i);
         c = ccnt;
         r = rcnt;
         access(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
         compare(10'(rcnt - r), 10'h000);
         k = int_pending_i & bus.priority_chain_in;
         compare({ius_o, 1'b0, rdata_o}, {k, 1'b0, (k & vector_enable_i) ? vector_i : 8'hff});
         compare(10'(ccnt - c), {9'h000, k});
         ius_clear_i <= 1'b1;
         @(posedge mclk_i);
         ius_clear_i <= 1'b0;
         @(posedge mclk_i);
         compare({9'h000, ius_o}, 10'h000);
      end
      tally_and_finish();
   end
endmodule
